// File: sgd_ctrl_props.sv
// assertion checker for the dma channel control block
`timescale 1ns/1ps
module sgd_ctrl_props #(
  parameter NCH = 4,
  parameter LEGACY_IRQ = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire reg_rvalid,
  // user side
  input wire [2*NCH-1:0] user_rst_req,
  input wire [2*NCH-1:0] user_rst
);
  // ==========
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire cmn = reg_addr == 16'h4000;
  wire ctl = reg_addr[7:0] == 8'h04 && reg_addr < 16'h4000;
  wire ptr = reg_addr[3:2] != 2'b01 && reg_addr[7:4] == 4'h0;
  wire wr0 = reg_wr && reg_addr == 16'h0004;

  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  hole_zero_a: assert property (reg_rd && reg_addr == 16'h0000
    |=> reg_rdata == 32'h0) else $error("hole not zero");
  ptr_align_a: assert property (reg_rd && ptr && !cmn
    |=> reg_rdata[4:0] == 5'h00) else $error("pointer low bits set");
  ctl_reserved_a: assert property (reg_rd && ctl
    |=> (reg_rdata & 32'hffff32c0) == 32'h0) else $error("ctrl reserved");
  run_wait_a: assert property (reg_rd && ctl
    |=> !(reg_rdata[10] && reg_rdata[11])) else $error("run and wait");
  gated_irq_a: assert property (reg_rd && cmn
    |=> reg_rdata[1] == (reg_rdata[0] && reg_rdata[2]))
    else $error("gated interrupt wrong");
  irq_mode_a: assert property (reg_rd && cmn
    |=> reg_rdata[3] == LEGACY_IRQ) else $error("mode bit wrong");
  absent_eng_a: assert property (reg_rd && cmn
    |=> (reg_rdata[23:16] >> NCH) == 8'h0 && (reg_rdata[31:24] >> NCH) == 8'h0
    && reg_rdata[15:6] == 10'h0) else $error("absent engine bit set");
  reset_req_a: assert property (wr0 && reg_wdata[14]
    |-> ##[1:2] user_rst_req[0]) else $error("reset request missing");
  user_reset_a: assert property (wr0 && reg_wdata[15]
    |-> ##[1:2] user_rst[0]) else $error("user reset missing");

  cover property (reg_rd && cmn);
  cover property ($rose(user_rst_req[0]));
  cover property ($rose(user_rst[0]));
endmodule

bind sgd_dma_ctrl sgd_ctrl_props #(
  .NCH(NCH),
  .LEGACY_IRQ(LEGACY_IRQ)
) u_props (
  .clk(clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .user_rst_req(user_rst_req),
  .user_rst(user_rst)
);

// File: sgd_dma_ctrl.v
// channel control and status for a multi-channel scatter-gather dma
`timescale 1ns/1ps
`include "sgd_map.vh"
module sgd_dma_ctrl #(
  parameter NCH = 4,
  parameter SAMPLE_CYC = `SGD_SAMPLE_CYC,
  parameter LEGACY_IRQ = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // bar0 register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  // engine events, one bit per engine, host-to-card low half
  input wire [2*NCH-1:0] desc_done,
  input wire [2*NCH-1:0] desc_ioc,
  input wire [2*NCH-1:0] desc_misaligned,
  input wire [2*NCH-1:0] fetch_bad,
  input wire [2*NCH-1:0] sw_abort,
  input wire [2*NCH-1:0] idle_done,
  // descriptor fetch requests through the fifo
  output wire desc_req_valid,
  input wire desc_req_ready,
  output wire [31:0] desc_req_addr,
  output wire [2:0] desc_req_chan,
  // data beats in four-byte units
  input wire [2*NCH-1:0] data_beat,
  // user logic reset handshake
  input wire [2*NCH-1:0] user_rst_ack,
  output reg [2*NCH-1:0] user_rst_req,
  output reg [2*NCH-1:0] user_rst,
  // user interrupt input, interrupt output
  input wire user_irq,
  output reg irq,
  output reg [2*NCH-1:0] engine_run
);
  localparam NE = 2 * NCH;
  localparam ST_IDLE = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_WAIT = 2'd3;

  // ==========================================================
  // register storage
  reg [NE-1:0] ien;
  reg [NE-1:0] iact;
  reg [NE-1:0] f_done;
  reg [NE-1:0] f_align;
  reg [NE-1:0] f_fetch;
  reg [NE-1:0] f_abort;
  reg [NE-1:0] en;
  reg [NE-1:0] rst_req;
  reg [NE-1:0] eng_rst;
  reg [26:0] nxt [0:NE-1];
  reg [26:0] lim [0:NE-1];
  reg [1:0] st [0:NE-1];
  reg gie;
  reg uien;
  reg uact;
  reg [NE-1:0] ack_m;
  reg [NE-1:0] ack_s;
  reg uirq_m;
  reg uirq_s;
  wire [31:0] bytes [0:NE-1];
  wire [NE-1:0] grant;
  wire [NE-1:0] want;
  wire fifo_ready;
  reg [2:0] pick;
  reg [NE-1:0] sel;
  integer k;
  integer ka;
  integer kc;
  integer kr;

  // ==========================================================
  // address decode helpers
  function sgd_hit;
    input [15:0] a;
    input integer e;
    input [11:0] ofs;
    reg [15:0] base;
    integer c;
    begin
      base = (e < NCH) ? `SGD_BASE_H2C : `SGD_BASE_C2H;
      c = (e % NCH) << `SGD_CH_STRIDE_SHIFT;
      base = base + c[15:0];
      sgd_hit = (a == base + {4'h0, ofs});
    end
  endfunction

  function [31:0] sgd_ctrl_word;
    input integer e;
    reg [31:0] w;
    begin
      w = 32'h00000000;
      w[`SGD_B_IEN] = ien[e];
      w[`SGD_B_IACT] = iact[e];
      w[`SGD_B_DONE] = f_done[e];
      w[`SGD_B_ALIGN] = f_align[e];
      w[`SGD_B_FETCH] = f_fetch[e];
      w[`SGD_B_ABORT] = f_abort[e];
      w[`SGD_B_EN] = en[e];
      w[`SGD_B_RUN] = (st[e] == ST_RUN) || (st[e] == ST_FETCH);
      w[`SGD_B_WAIT] = (st[e] == ST_WAIT);
      w[`SGD_B_RSTREQ] = rst_req[e];
      w[`SGD_B_RST] = eng_rst[e];
      sgd_ctrl_word = w;
    end
  endfunction

  // ==========================================================
  // input synchronisers for user logic pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_m <= {NE{1'b0}};
      ack_s <= {NE{1'b0}};
      uirq_m <= 1'b0;
      uirq_s <= 1'b0;
    end else begin
      ack_m <= user_rst_ack;
      ack_s <= ack_m;
      uirq_m <= user_irq;
      uirq_s <= uirq_m;
    end
  end

  // ==========================================================
  // per-engine byte rate counters
  genvar g;
  generate
    for (g = 0; g < NE; g = g + 1) begin : rate
      sgd_rate #(
        .SAMPLE_CYC(SAMPLE_CYC)
      ) u_rate (
        .clk(clk),
        .rst(rst || eng_rst[g]),
        .beat(data_beat[g]),
        .sample(bytes[g])
      );
    end
  endgenerate

  // ==========================================================
  // fetch arbitration: lowest engine wanting a descriptor
  generate
    for (g = 0; g < NE; g = g + 1) begin : req
      assign want[g] = (st[g] == ST_FETCH);
      assign grant[g] = sel[g] && fifo_ready;
    end
  endgenerate

  always @* begin
    pick = 3'd0;
    sel = {NE{1'b0}};
    for (ka = NE - 1; ka >= 0; ka = ka - 1) begin
      if (want[ka]) begin
        pick = ka[2:0];
        sel = {NE{1'b0}};
        sel[ka] = 1'b1;
      end
    end
  end

  sgd_fifo #(
    .WIDTH(35),
    .DEPTH(16),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(|want),
    .in_ready(fifo_ready),
    .in_data({pick, nxt[pick], 5'h00}),
    .out_valid(desc_req_valid),
    .out_ready(desc_req_ready),
    .out_data({desc_req_chan, desc_req_addr})
  );

  // ==========================================================
  // engine control, flags and pointers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ien <= {NE{1'b0}};
      iact <= {NE{1'b0}};
      f_done <= {NE{1'b0}};
      f_align <= {NE{1'b0}};
      f_fetch <= {NE{1'b0}};
      f_abort <= {NE{1'b0}};
      en <= {NE{1'b0}};
      rst_req <= {NE{1'b0}};
      eng_rst <= {NE{1'b0}};
      for (k = 0; k < NE; k = k + 1) begin
        nxt[k] <= 27'h0000000;
        lim[k] <= 27'h0000000;
        st[k] <= ST_IDLE;
      end
    end else begin
      for (k = 0; k < NE; k = k + 1) begin
        if (reg_wr && sgd_hit(reg_addr, k, `SGD_OFS_CTRL)) begin
          ien[k] <= reg_wdata[`SGD_B_IEN];
          en[k] <= reg_wdata[`SGD_B_EN];
          rst_req[k] <= reg_wdata[`SGD_B_RSTREQ];
          eng_rst[k] <= reg_wdata[`SGD_B_RST];
        end
        if (reg_wr && sgd_hit(reg_addr, k, `SGD_OFS_NEXT)) begin
          nxt[k] <= reg_wdata[31:`SGD_PTR_LO];
        end
        if (reg_wr && sgd_hit(reg_addr, k, `SGD_OFS_LIMIT)) begin
          lim[k] <= reg_wdata[31:`SGD_PTR_LO];
        end
        // write-one-clear, then events set and win
        if (reg_wr && sgd_hit(reg_addr, k, `SGD_OFS_CTRL)) begin
          iact[k] <= (iact[k] & ~reg_wdata[`SGD_B_IACT]) |
            (ien[k] & (desc_done[k] & desc_ioc[k] | desc_misaligned[k] |
            fetch_bad[k] | sw_abort[k]));
          f_done[k] <= (f_done[k] & ~reg_wdata[`SGD_B_DONE]) |
            (desc_done[k] & desc_ioc[k]);
          f_align[k] <= (f_align[k] & ~reg_wdata[`SGD_B_ALIGN]) |
            desc_misaligned[k];
          f_fetch[k] <= (f_fetch[k] & ~reg_wdata[`SGD_B_FETCH]) |
            fetch_bad[k];
          f_abort[k] <= (f_abort[k] & ~reg_wdata[`SGD_B_ABORT]) |
            sw_abort[k];
        end else begin
          iact[k] <= iact[k] | (ien[k] & (desc_done[k] & desc_ioc[k] |
            desc_misaligned[k] | fetch_bad[k] | sw_abort[k]));
          f_done[k] <= f_done[k] | (desc_done[k] & desc_ioc[k]);
          f_align[k] <= f_align[k] | desc_misaligned[k];
          f_fetch[k] <= f_fetch[k] | fetch_bad[k];
          f_abort[k] <= f_abort[k] | sw_abort[k];
        end
        if (rst_req[k] && ack_s[k]) begin
          rst_req[k] <= 1'b0;
        end
        // engine sequencer
        if (eng_rst[k]) begin
          st[k] <= ST_IDLE;
        end else begin
          case (st[k])
            ST_IDLE: begin
              if (en[k]) begin
                st[k] <= (nxt[k] != lim[k]) ? ST_FETCH : ST_WAIT;
              end
            end
            ST_FETCH: begin
              if (grant[k]) begin
                st[k] <= ST_RUN;
              end
            end
            ST_RUN: begin
              if (desc_misaligned[k] || fetch_bad[k] || sw_abort[k]) begin
                st[k] <= ST_IDLE;
              end else if (desc_done[k]) begin
                nxt[k] <= nxt[k] + 27'h0000001;
                st[k] <= ST_IDLE;
              end
            end
            ST_WAIT: begin
              if (!en[k] || nxt[k] != lim[k]) begin
                st[k] <= ST_IDLE;
              end
            end
            default: begin
              st[k] <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // common register, interrupt and outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gie <= 1'b0;
      uien <= 1'b0;
      uact <= 1'b0;
      irq <= 1'b0;
      user_rst_req <= {NE{1'b0}};
      user_rst <= {NE{1'b0}};
      engine_run <= {NE{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `SGD_ADR_COMMON) begin
        gie <= reg_wdata[`SGD_B_GIE];
        uien <= reg_wdata[`SGD_B_UIEN];
        uact <= (uact & ~reg_wdata[`SGD_B_UACT]) | (uien & uirq_s);
      end else begin
        uact <= uact | (uien & uirq_s);
      end
      irq <= gie & ((|iact) | uact);
      user_rst_req <= rst_req;
      user_rst <= eng_rst;
      for (kc = 0; kc < NE; kc = kc + 1) begin
        engine_run[kc] <= (st[kc] == ST_RUN);
      end
    end
  end

  // ==========================================================
  // register read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `SGD_RESET_VAL;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == `SGD_ADR_COMMON) begin
          reg_rdata[`SGD_B_GIE] <= gie;
          reg_rdata[`SGD_B_GACT] <= gie & ((|iact) | uact);
          reg_rdata[`SGD_B_GPEND] <= (|iact) | uact;
          reg_rdata[`SGD_B_MODE] <= LEGACY_IRQ;
          reg_rdata[`SGD_B_UIEN] <= uien;
          reg_rdata[`SGD_B_UACT] <= uact;
          reg_rdata[`SGD_B_H2C_LO +: NCH] <= iact[NCH-1:0];
          reg_rdata[`SGD_B_C2H_LO +: NCH] <= iact[NE-1:NCH];
        end
        for (kr = 0; kr < NE; kr = kr + 1) begin
          if (sgd_hit(reg_addr, kr, `SGD_OFS_CTRL)) begin
            reg_rdata <= sgd_ctrl_word(kr);
          end
          if (sgd_hit(reg_addr, kr, `SGD_OFS_NEXT)) begin
            reg_rdata <= {nxt[kr], 5'h00};
          end
          if (sgd_hit(reg_addr, kr, `SGD_OFS_LIMIT)) begin
            reg_rdata <= {lim[kr], 5'h00};
          end
          if (sgd_hit(reg_addr, kr, `SGD_OFS_BYTES)) begin
            reg_rdata <= bytes[kr];
          end
        end
      end
    end
  end
endmodule

// File: sgd_fifo.v
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module sgd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// File: sgd_map.vh
// register map constants for the scatter-gather dma channel control block
// Function
// - each channel register sits at channel base plus register offset.
// - bit 1 sets on any interrupt event, write one clears; bit 0 enables.
// - bit 2 flags completion of a descriptor with interrupt-on-completion.
// - unsuccessful descriptor fetch sets bit 4 and raises interrupt.
// - software abort of an operation sets bit 5.
// - with enable bit 8, run while next and limit pointers differ.
// - read-only bit 10 is high while the engine transfers.
// - read-only bit 11 is high while waiting for more descriptors.
// - bit 14 requests user logic prepare for reset; cleared on acknowledge.
// - bit 15 resets the engine and drives reset to user logic.
// - next pointer bits 31..5 give the next descriptor to fetch.
// - low five bits of both pointer registers read as zero.
// - bits 31..2 report bytes moved in previous second, four-byte units.
// - two-bit sample count increments at each one-second sample.
// - common bit 0 globally enables interrupts of all engines.
// - common bit 1 shows gated interrupt, bit 2 ungated pending.
// - common bit 3 shows interrupt mode, 0 msi, 1 legacy.
// - common bit 4 enables user interrupts; bit 5 active, write one clears.
// - common bits 23..16 show host-to-card engine interrupt status.
// - common bits 31..24 show card-to-host engine interrupt status.
// - host-to-card bases 0x100 apart from zero, card-to-host from 0x2000.
// - reserved bits and holes read zero; registers reset to defaults.
`ifndef SGD_MAP_VH
`define SGD_MAP_VH
`define SGD_OFS_CTRL 12'h004
`define SGD_OFS_NEXT 12'h008
`define SGD_OFS_LIMIT 12'h00c
`define SGD_OFS_BYTES 12'h01c
`define SGD_ADR_COMMON 16'h4000
`define SGD_BASE_H2C 16'h0000
`define SGD_BASE_C2H 16'h2000
`define SGD_CH_STRIDE_SHIFT 8
`define SGD_B_IEN 0
`define SGD_B_IACT 1
`define SGD_B_DONE 2
`define SGD_B_ALIGN 3
`define SGD_B_FETCH 4
`define SGD_B_ABORT 5
`define SGD_B_EN 8
`define SGD_B_RUN 10
`define SGD_B_WAIT 11
`define SGD_B_RSTREQ 14
`define SGD_B_RST 15
`define SGD_B_GIE 0
`define SGD_B_GACT 1
`define SGD_B_GPEND 2
`define SGD_B_MODE 3
`define SGD_B_UIEN 4
`define SGD_B_UACT 5
`define SGD_B_H2C_LO 16
`define SGD_B_C2H_LO 24
`define SGD_PTR_LO 5
`define SGD_RESET_VAL 32'h00000000
`define SGD_SAMPLE_NS 1000000000
`define SGD_CLK_NS 20
`define SGD_SAMPLE_CYC (`SGD_SAMPLE_NS / `SGD_CLK_NS)
`endif

// File: sgd_rate.v
// one-second completed byte counter with two-bit sample count
`timescale 1ns/1ps
`include "sgd_map.vh"
module sgd_rate #(
  parameter SAMPLE_CYC = `SGD_SAMPLE_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // byte beats, counted in four-byte units
  input wire beat,
  // sampled value
  output reg [31:0] sample
);
  reg [31:0] tick;
  reg [29:0] acc;
  wire last;
  assign last = (tick == SAMPLE_CYC - 1);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick <= 32'h00000000;
      acc <= 30'h00000000;
      sample <= `SGD_RESET_VAL;
    end else begin
      tick <= last ? 32'h00000000 : tick + 32'h00000001;
      if (last) begin
        acc <= {29'h00000000, beat};
        sample[31:2] <= acc + {29'h00000000, beat};
        sample[1:0] <= sample[1:0] + 2'h1;
      end else begin
        acc <= acc + {29'h00000000, beat};
      end
    end
  end
endmodule

// File: sgd_user_model.sv
// user logic model: reset handshake and fetch request drain
`timescale 1ns/1ps
module sgd_user_model (
  // clock and reset
  input wire clk,
  input wire rst,
  // reset handshake
  input wire [7:0] user_rst_req,
  output reg [7:0] user_rst_ack,
  // fetch drain
  input wire stall,
  output reg desc_req_ready
);
  reg [7:0] seen;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seen <= 8'h00;
      user_rst_ack <= 8'h00;
      desc_req_ready <= 1'b0;
    end else begin
      seen <= user_rst_req;
      // ack a held request, drop with it
      user_rst_ack <= seen & user_rst_req;
      desc_req_ready <= !stall;
    end
  end
endmodule

// File: tb.sv
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
module tb;
  reg clk, rst, reg_wr, reg_rd, uirq, stall;
  reg [15:0] reg_addr;
  reg [31:0] reg_wdata, v, w;
  reg [39:0] ev;
  reg [7:0] beat;
  wire [31:0] reg_rdata, daddr;
  wire reg_rvalid, dvalid, dready, irq;
  wire [7:0] ack, ureq, urst, run;
  wire [2:0] dchan;
  integer fails, checked, cyc, i, n;
  sgd_dma_ctrl #(.NCH(4), .SAMPLE_CYC(100), .LEGACY_IRQ(1'b0)) u_dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .desc_done(ev[7:0]), .desc_ioc(ev[15:8]),
    .desc_misaligned(ev[23:16]), .fetch_bad(ev[31:24]),
    .sw_abort(ev[39:32]), .idle_done(8'h00), .desc_req_valid(dvalid),
    .desc_req_ready(dready), .desc_req_addr(daddr), .desc_req_chan(dchan),
    .data_beat(beat), .user_rst_ack(ack), .user_rst_req(ureq),
    .user_rst(urst), .user_irq(uirq), .irq(irq), .engine_run(run));
  sgd_user_model u_user (.clk(clk), .rst(rst), .user_rst_req(ureq),
    .user_rst_ack(ack), .stall(stall), .desc_req_ready(dready));
  // ==========
  // helpers
  task check(input [127:0] name, input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [15:0] a);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
      check("rvalid", {31'h0, reg_rvalid}, 32'h1);
    end
  endtask
  task pulse(input [39:0] e);
    begin
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 40'h0;
    end
  endtask
  // ==========
  // scenarios
  task t_reset;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        w = (i % 4 == 3) ? 32'h1c : (i % 4 + 1) * 4;
        rd((i < 4 ? 16'h0000 : 16'h2300) + w[15:0]);
        check("reset value", v, 32'h0);
      end
      rd(16'h4000);
      check("common reset", v, 32'h0);
      rd(16'h4004);
      check("hole", v, 32'h0);
      rd(16'h0000);
      check("low hole", v, 32'h0);
    end
  endtask
  task t_causes;
    begin
      pulse(40'h40 << 32);
      rd(16'h2204);
      check("abort no ien", v, 32'h20);
      wr(16'h2204, 32'h21);
      for (i = 0; i < 4; i = i + 1) begin
        pulse(i == 0 ? 40'h4040 : 40'h40 << (8 * i + 8));
        rd(16'h2204);
        check("cause", v, 32'h3 | 32'h4 << i);
        rd(16'h4000);
        check("pending", v, 32'h04000004);
        check("irq gated", {31'h0, irq}, 32'h0);
        wr(16'h2204, 32'h3 | (32'h4 << i));
        rd(16'h2204);
        check("w1c", v, 32'h1);
      end
      pulse(40'h4040);
      wr(16'h4000, 32'h1);
      rd(16'h4000);
      check("gie on", v, 32'h04000007);
      check("irq on", {31'h0, irq}, 32'h1);
      wr(16'h2204, 32'h6);
      wr(16'h4000, 32'h0);
    end
  endtask
  task t_urst;
    begin
      wr(16'h0004, 32'h4000);
      v = 32'h4000;
      for (n = 0; n < 20 && v[14]; n = n + 1) rd(16'h0004);
      check("req cleared", v, 32'h0);
      check("req pin", {24'h0, ureq}, 32'h0);
      wr(16'h0004, 32'h8000);
      rd(16'h0004);
      check("user rst", {24'h0, urst}, 32'h1);
      wr(16'h0004, 32'h0);
      rd(16'h0004);
      check("user rst off", {24'h0, urst}, 32'h0);
    end
  endtask
  task t_ptr;
    begin
      stall <= 1'b1;
      wr(16'h0008, 32'h1000001f);
      rd(16'h0008);
      check("next ptr", v, 32'h10000000);
      wr(16'h000c, 32'h1000001f);
      rd(16'h000c);
      check("limit ptr", v, 32'h10000000);
      wr(16'h0004, 32'h100);
      rd(16'h0004);
      check("waiting", v, 32'h900);
      wr(16'h000c, 32'h10000040);
      @(posedge clk);
      rd(16'h0004);
      check("running", v & 32'hc00, 32'h400);
      check("fetch valid", {31'h0, dvalid}, 32'h1);
      check("fetch addr", daddr, 32'h10000000);
      check("fetch chan", {29'h0, dchan}, 32'h0);
      @(posedge clk);
      stall <= 1'b0;
      #1;
      check("run pin on", {24'h0, run}, 32'h1);
      for (i = 1; i < 3; i = i + 1) begin
        pulse(40'h1);
        rd(16'h0008);
        check("next step", v, 32'h10000000 + 32 * i);
      end
      rd(16'h0004);
      check("idle again", v, 32'h900);
      check("run pin", {24'h0, run}, 32'h0);
    end
  endtask
  task t_user;
    begin
      wr(16'h4000, 32'h10);
      uirq <= 1'b1;
      repeat (4) @(posedge clk);
      uirq <= 1'b0;
      rd(16'h4000);
      check("user act", v & 32'h30, 32'h30);
      wr(16'h4000, 32'h30);
      rd(16'h4000);
      check("user clr", v & 32'h30, 32'h10);
    end
  endtask
  task t_rate;
    begin
      rd(16'h001c);
      w = v;
      for (n = 0; n < 60 && v[1:0] == w[1:0]; n = n + 1) rd(16'h001c);
      w = v;
      @(posedge clk);
      beat <= 8'h01;
      repeat (10) @(posedge clk);
      beat <= 8'h00;
      for (n = 0; n < 60 && v[1:0] == w[1:0]; n = n + 1) rd(16'h001c);
      check("byte count", v, {30'd10, w[1:0] + 2'd1});
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // ==========
  // run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, uirq, stall} = 5'b10000;
    {reg_addr, reg_wdata, ev, beat} = 96'h0;
    {fails, checked, cyc} = 96'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_causes;
    t_urst;
    t_ptr;
    t_user;
    t_rate;
    end_of_test;
  end
endmodule
